// ---- bench/ssa_layout_assertions.sv ----
`timescale 1ns/1ps
module ssa_layout_assertions
	import ssa_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Requests
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire ssa_pkg::ssa_off_t req_offset_i,
	input wire logic [7:0] req_wdata_i,
	input wire logic mode64_i,
	// Answers
	input wire logic req_refused_o,
	input wire ssa_pkg::ssa_field_t req_field_o,
	input wire logic restore_valid_o,
	input wire logic gp_fault_o,
	input wire logic fmt_compacted_o,
	input wire ssa_pkg::ssa_word_t mem_addr_o,
	input wire logic mem_we_o,
	input wire logic mem_re_o,
	input wire logic [7:0] mem_be_o,
	input wire ssa_pkg::ssa_word_t mem_wdata_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	function automatic logic bad(ssa_off_t o, logic m);
		return o == 10'h005 || (o >= 32 && o < 160 && o[3:0] >= 4'hA) || (o >= 416 && o < 512)
			|| (o >= 528 && o < 576) || (!m && o >= 288 && o < 416);
	endfunction : bad
	wire logic go = req_valid_i && !bad(req_offset_i, mode64_i);
	sequence s_fetch;
		mem_re_o && !mem_we_o ##2 restore_valid_o;
	endsequence
	property p_refuse;
		req_valid_i && bad(req_offset_i, mode64_i) |=> req_refused_o && !mem_we_o && !mem_re_o;
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused offset reached memory");
	property p_save;
		go && req_write_i |=> mem_we_o && mem_wdata_o == {8{$past(req_wdata_i)}};
	endproperty
	a_save: assert property (p_save) else $error("save byte not issued");
	property p_restore;
		go && !req_write_i |=> s_fetch;
	endproperty
	a_restore: assert property (p_restore) else $error("restore byte not returned");
	property p_lane;
		mem_be_o == ((mem_we_o || mem_re_o) ? 8'h01 << mem_addr_o[2:0] : 8'h00);
	endproperty
	a_lane: assert property (p_lane) else $error("byte lane wrong");
	property p_hdr_pres;
		req_valid_i && req_offset_i[9:3] == 7'h40 |=> req_field_o == SSA_FLD_PRES;
	endproperty
	a_hdr_pres: assert property (p_hdr_pres) else $error("presence field wrong");
	property p_hdr_comp;
		req_valid_i && req_offset_i[9:3] == 7'h41 |=> req_field_o == SSA_FLD_COMP;
	endproperty
	a_hdr_comp: assert property (p_hdr_comp) else $error("compaction field wrong");
	property p_stk;
		go && req_offset_i >= 32 && req_offset_i < 160 |=> req_field_o == SSA_FLD_STK;
	endproperty
	a_stk: assert property (p_stk) else $error("stack slot field wrong");
	property p_vec;
		go && req_offset_i >= 160 && req_offset_i < 416 |=> req_field_o == SSA_FLD_VEC;
	endproperty
	a_vec: assert property (p_vec) else $error("vector slot field wrong");
	property p_fmt;
		req_valid_i && req_write_i && req_offset_i == 10'h20F && req_wdata_i[7] |-> ##[1:3] fmt_compacted_o;
	endproperty
	a_fmt: assert property (p_fmt) else $error("compacted format not shown");
	property p_gp;
		gp_fault_o |-> restore_valid_o && $past(mem_re_o, 2);
	endproperty
	a_gp: assert property (p_gp) else $error("fault outside a restore");
endmodule : ssa_layout_assertions
bind ssa_layout ssa_layout_assertions i_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_offset_i(req_offset_i),
	.req_wdata_i(req_wdata_i), .mode64_i(mode64_i), .req_refused_o(req_refused_o),
	.req_field_o(req_field_o), .restore_valid_o(restore_valid_o), .gp_fault_o(gp_fault_o),
	.fmt_compacted_o(fmt_compacted_o), .mem_addr_o(mem_addr_o), .mem_we_o(mem_we_o),
	.mem_re_o(mem_re_o), .mem_be_o(mem_be_o), .mem_wdata_o(mem_wdata_o));

// ---- bench/ssa_mem_model.sv ----
`timescale 1ns/1ps
module ssa_mem_model
	import ssa_pkg::*;
(
	input wire logic clk_sys_i,
	input wire ssa_pkg::ssa_word_t addr_i,
	input wire logic we_i,
	input wire logic re_i,
	input wire ssa_pkg::ssa_word_t wdata_i,
	output ssa_pkg::ssa_word_t rdata_o
);
	logic [7:0] img [ssa_word_t];
	initial rdata_o = '0;
	// Outside the answer cycle the bus toggles, so a late sample shows up as a mismatch.
	always @(posedge clk_sys_i) begin
		if (we_i) begin
			img[addr_i] = wdata_i[7:0];
		end
		if (re_i) begin
			rdata_o <= {8{img.exists(addr_i) ? img[addr_i] : 8'h00}};
		end else begin
			rdata_o <= ~rdata_o;
		end
	end
endmodule : ssa_mem_model

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
	import ssa_pkg::*;
	logic clk_sys_i = 0;
	logic rst_i = 1;
	logic [7:0] reg_addr_i = '0;
	logic [31:0] reg_wdata_i = '0;
	logic reg_we_i = 0;
	logic reg_re_i = 0;
	logic req_valid_i = 0;
	logic req_write_i = 0;
	ssa_off_t req_offset_i = '0;
	logic [7:0] req_wdata_i = '0;
	logic mode64_i = 1;
	logic [31:0] reg_rdata_o, rd;
	logic req_refused_o, restore_valid_o, gp_fault_o, fmt_compacted_o, restore_compacted_o;
	logic mem_we_o, mem_re_o, gp;
	ssa_field_t req_field_o;
	logic [7:0] restore_data_o, mem_be_o;
	ssa_word_t mem_addr_o, mem_wdata_o, mem_rdata_i, base;
	logic [7:0] shadow [ssa_off_t];
	int fails = 0;
	int checks = 0;
	ssa_off_t probe [17] = '{0, 2, 4, 5, 6, 8, 16, 24, 28, 32, 42, 160, 416, 512, 520, 528, 576};
	always #20 clk_sys_i = ~clk_sys_i;
	ssa_layout i_ssa_layout (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
		.req_offset_i(req_offset_i), .req_wdata_i(req_wdata_i), .mode64_i(mode64_i),
		.req_refused_o(req_refused_o), .req_field_o(req_field_o),
		.restore_data_o(restore_data_o), .restore_valid_o(restore_valid_o),
		.gp_fault_o(gp_fault_o), .fmt_compacted_o(fmt_compacted_o),
		.restore_compacted_o(restore_compacted_o), .mem_addr_o(mem_addr_o),
		.mem_we_o(mem_we_o), .mem_re_o(mem_re_o), .mem_be_o(mem_be_o),
		.mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));
	ssa_mem_model i_ssa_mem_model (.clk_sys_i(clk_sys_i), .addr_i(mem_addr_o), .we_i(mem_we_o),
		.re_i(mem_re_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
	function automatic logic refused(ssa_off_t o, logic m);
		return o == 5 || (o >= 32 && o < 160 && o[3:0] >= 10) || (o >= 416 && o < 512)
			|| (o >= 528 && o < 576) || (!m && o >= 288 && o < 416);
	endfunction : refused
	function automatic ssa_field_t exp_field(ssa_off_t o);
		if (o < 2) return SSA_FLD_FCW;
		if (o < 4) return SSA_FLD_FSW;
		if (o == 4) return SSA_FLD_TAG;
		if (o == 5) return SSA_FLD_RSVD;
		if (o < 8) return SSA_FLD_FOP;
		if (o < 16) return SSA_FLD_FIP;
		if (o < 24) return SSA_FLD_FDP;
		if (o < 28) return SSA_FLD_VCS;
		if (o < 32) return SSA_FLD_VMASK;
		if (o < 160) return (o[3:0] < 10) ? SSA_FLD_STK : SSA_FLD_RSVD;
		if (o < 416) return SSA_FLD_VEC;
		if (o < 512) return SSA_FLD_RSVD;
		if (o < 520) return SSA_FLD_PRES;
		if (o < 528) return SSA_FLD_COMP;
		if (o < 576) return SSA_FLD_RSVD;
		return SSA_FLD_EXT;
	endfunction : exp_field
	task automatic test_done();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic reg_wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys_i);
		reg_we_i <= 1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_we_i <= 0;
	endtask : reg_wr
	task automatic reg_rd(logic [7:0] a);
		@(posedge clk_sys_i);
		reg_re_i <= 1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_re_i <= 0;
		#1 rd = reg_rdata_o;
	endtask : reg_rd
	task automatic req(logic w, ssa_off_t o, logic [7:0] d);
		int n;
		@(posedge clk_sys_i);
		req_valid_i <= 1;
		req_write_i <= w;
		req_offset_i <= o;
		req_wdata_i <= d;
		@(posedge clk_sys_i);
		req_valid_i <= 0;
		#1 check("refused", req_refused_o, refused(o, mode64_i));
		check("req field", req_field_o, exp_field(o));
		check("access", {mem_we_o, mem_re_o}, refused(o, mode64_i) ? 2'b00 : {w, !w});
		if (refused(o, mode64_i)) return;
		check("addr", mem_addr_o, base + o);
		check("lane", mem_be_o, 8'h01 << o[2:0]);
		if (w) begin
			check("wdata", mem_wdata_o, {8{d}});
			shadow[o] = d;
			return;
		end
		for (n = 0; n < 6 && restore_valid_o !== 1'b1; n++) begin
			@(posedge clk_sys_i);
			#1;
		end
		if (n == 6) begin
			check("restore wait", 1'b0, 1'b1);
			test_done();
		end
		gp = gp_fault_o;
		check("restore", restore_data_o, shadow.exists(o) ? shadow[o] : 8'h00);
	endtask : req
	initial begin
		ssa_off_t o;
		void'($urandom(32'h86f5));
		repeat (4) @(posedge clk_sys_i);
		rst_i <= 0;
		reg_rd(8'h08);
		check("vmask", rd, 32'h0000FFFF);
		reg_rd(8'h0C);
		check("status", rd, 32'h0);
		reg_rd(8'h24);
		check("unmapped", rd, 32'h0);
		base = {$urandom, $urandom};
		reg_wr(8'h00, base[31:0]);
		reg_wr(8'h04, base[63:32]);
		base[5:0] = 6'h00;
		reg_rd(8'h00);
		check("base", rd, base[31:0]);
		for (int i = 0; i < 60; i++) begin
			o = (i < 17) ? probe[i] : 10'($urandom_range(0, 1023));
			reg_wr(8'h20, {22'h0, o});
			reg_rd(8'h20);
			check("field", rd[3:0], exp_field(o));
			@(posedge clk_sys_i);
			mode64_i <= 1'($urandom);
			// Compaction bytes stay zero here: this image writer uses no compaction.
			req(1'($urandom), o, (o[9:3] == 7'h41) ? 8'h00 : 8'($urandom));
		end
		@(posedge clk_sys_i);
		mode64_i <= 1;
		// Header bitmaps, then the format and restore-form selection both ways.
		req(1, 10'h200, 8'h5A);
		reg_rd(8'h10);
		check("presence", rd[7:0], 8'h5A);
		req(1, 10'h20F, 8'h80);
		reg_rd(8'h1C);
		check("comp hi", rd[31:24], 8'h80);
		check("fmt", fmt_compacted_o, 1);
		req(0, 10'h20F, 8'h00);
		@(posedge clk_sys_i);
		#1 check("form", restore_compacted_o, 1);
		req(1, 10'h20F, 8'h00);
		req(0, 10'h20F, 8'h00);
		@(posedge clk_sys_i);
		#1 check("form", restore_compacted_o, 0);
		check("fmt", fmt_compacted_o, 0);
		// Control word with bit 16 set lies outside the reset mask.
		for (int k = 0; k < 4; k++) req(1, 10'(24 + k), (k == 2) ? 8'h01 : 8'h00);
		for (int k = 0; k < 4; k++) req(0, 10'(24 + k), 8'h00);
		check("gp", gp, 1);
		reg_rd(8'h0C);
		check("gp sticky", rd[1], 1);
		check("ref sticky", rd[2], 1);
		check("fmt bit", rd[0], 0);
		reg_wr(8'h0C, 32'h2);
		reg_rd(8'h0C);
		check("gp clear", rd[1], 0);
		reg_wr(8'h08, 32'h0001FFFF);
		for (int k = 0; k < 4; k++) req(0, 10'(24 + k), 8'h00);
		check("gp", gp, 0);
		test_done();
	end
endmodule : tb

// ---- core/ssa_addr_gen.sv ----
`timescale 1ns/1ps
module ssa_addr_gen (
	// Base and offset in, address out
	ssa_map_if.agen a
);
	import ssa_pkg::*;
	assign a.addr = a.base + {54'h0, a.off};
	assign a.lane = a.addr[2:0];
	// Byte k of a field lands at the next higher address, so the lane is the
	// low address bits and the word stays little-endian.
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_lane
			assign a.be[i] = (a.lane == 3'(i));
		end
	endgenerate
endmodule : ssa_addr_gen

// ---- core/ssa_defines.svh ----
`ifndef SSA_DEFINES_SVH
`define SSA_DEFINES_SVH
// Summary of operation
// - Legacy region fills image bytes 0 to 511.
// - Component 0 is stack state, 1 vector state.
// - Stack state uses bytes 23:0 and 159:32.
// - Vector state uses bytes 31:24 and 415:160.
// - Bytes 511:416 unused; 463:416 reserved.
// - Control, status, tag byte, last opcode placement.
// - Eight 16-byte stack slots, low 80 bits used.
// - Vector control word, mask; reserved bits fault.
// - Vector slots 0-7 then 8-15, 64-bit only.
// - 64-byte header starts at offset 512.
// - Header bytes 7:0 hold the presence bitmap.
// - Header bytes 15:8 hold the compaction bitmap.
// - Compaction bit 63 selects compacted format.
// - Compaction bit 63 selects compacted restore form.
// - Header bytes 63:16 reserved, hold no state.

// ==========================================================
// Image layout offsets
`define SSA_FCW_OFF 10'h000
`define SSA_FSW_OFF 10'h002
`define SSA_TAG_OFF 10'h004
`define SSA_RSV5_OFF 10'h005
`define SSA_FOP_OFF 10'h006
`define SSA_FIP_OFF 10'h008
`define SSA_FDP_OFF 10'h010
`define SSA_VCS_OFF 10'h018
`define SSA_VMASK_OFF 10'h01C
`define SSA_STK_OFF 10'h020
`define SSA_VEC_OFF 10'h0A0
`define SSA_UNUSED_OFF 10'h1A0
`define SSA_RSV_END_OFF 10'h1D0
`define SSA_HDR_OFF 10'h200
`define SSA_COMP_OFF 10'h208
`define SSA_HDR_RSV_OFF 10'h210
`define SSA_EXT_OFF 10'h240
`define SSA_STK_USED 4'hA
`define SSA_VCS_LAST 4'h3
`define SSA_BM_LAST 4'h7
`define SSA_FMT_BIT 63
`define SSA_BASE_ALIGN 6
// ==========================================================
// Register port map and reset values
`define SSA_REG_BASE_LO 8'h00
`define SSA_REG_BASE_HI 8'h04
`define SSA_REG_VMASK 8'h08
`define SSA_REG_STATUS 8'h0C
`define SSA_REG_PRES_LO 8'h10
`define SSA_REG_PRES_HI 8'h14
`define SSA_REG_COMP_LO 8'h18
`define SSA_REG_COMP_HI 8'h1C
`define SSA_REG_LOOKUP 8'h20
`define SSA_VMASK_RST 32'h0000FFFF
`define SSA_ST_FMT 0
`define SSA_ST_GP 1
`define SSA_ST_REFUSE 2
`define SSA_ST_FORM 3
`endif

// ---- core/ssa_field_map.sv ----
`timescale 1ns/1ps
`include "ssa_defines.svh"
module ssa_field_map (
	// Offset in, field out
	ssa_map_if.mapper m
);
	import ssa_pkg::*;
	ssa_off_t start;
	ssa_off_t diff;
	ssa_off_t stk_diff;
	assign stk_diff = m.off - `SSA_STK_OFF;
	assign diff = m.off - start;
	assign m.fbyte = diff[3:0];
	assign m.rsvd = (m.fld == SSA_FLD_RSVD);
	// ==========================================================
	// Decode
	always_comb begin
		m.fld = SSA_FLD_RSVD;
		start = m.off;
		m.comp_fpu = 1'b0;
		m.comp_vec = 1'b0;
		m.reg_idx = 4'h0;
		if (m.off >= `SSA_EXT_OFF) begin
			m.fld = SSA_FLD_EXT;
			start = `SSA_EXT_OFF;
		end else if (m.off >= `SSA_HDR_RSV_OFF) begin
			m.fld = SSA_FLD_RSVD;
		end else if (m.off >= `SSA_COMP_OFF) begin
			m.fld = SSA_FLD_COMP;
			start = `SSA_COMP_OFF;
		end else if (m.off >= `SSA_HDR_OFF) begin
			m.fld = SSA_FLD_PRES;
			start = `SSA_HDR_OFF;
		end else if (m.off >= `SSA_UNUSED_OFF) begin
			m.fld = SSA_FLD_RSVD;
		end else if (m.off >= `SSA_VEC_OFF) begin
			m.fld = SSA_FLD_VEC;
			start = {m.off[9:4], 4'h0};
			m.comp_vec = 1'b1;
			m.reg_idx = 4'(diff_idx(m.off - `SSA_VEC_OFF));
		end else if (m.off >= `SSA_STK_OFF) begin
			start = {m.off[9:4], 4'h0};
			m.reg_idx = {1'b0, stk_diff[6:4]};
			if (stk_diff[3:0] < `SSA_STK_USED) begin
				m.fld = SSA_FLD_STK;
				m.comp_fpu = 1'b1;
			end
		end else if (m.off >= `SSA_VMASK_OFF) begin
			m.fld = SSA_FLD_VMASK;
			start = `SSA_VMASK_OFF;
			m.comp_vec = 1'b1;
		end else if (m.off >= `SSA_VCS_OFF) begin
			m.fld = SSA_FLD_VCS;
			start = `SSA_VCS_OFF;
			m.comp_vec = 1'b1;
		end else begin
			m.comp_fpu = 1'b1;
			if (m.off >= `SSA_FDP_OFF) begin
				m.fld = SSA_FLD_FDP;
				start = `SSA_FDP_OFF;
			end else if (m.off >= `SSA_FIP_OFF) begin
				m.fld = SSA_FLD_FIP;
				start = `SSA_FIP_OFF;
			end else if (m.off >= `SSA_FOP_OFF) begin
				m.fld = SSA_FLD_FOP;
				start = `SSA_FOP_OFF;
			end else if (m.off == `SSA_RSV5_OFF) begin
				m.comp_fpu = 1'b0;
			end else if (m.off == `SSA_TAG_OFF) begin
				m.fld = SSA_FLD_TAG;
				start = `SSA_TAG_OFF;
			end else if (m.off >= `SSA_FSW_OFF) begin
				m.fld = SSA_FLD_FSW;
				start = `SSA_FSW_OFF;
			end else begin
				m.fld = SSA_FLD_FCW;
				start = `SSA_FCW_OFF;
			end
		end
	end

	function automatic logic [3:0] diff_idx(input ssa_off_t d);
		diff_idx = d[7:4];
	endfunction : diff_idx
endmodule : ssa_field_map

// ---- core/ssa_layout.sv ----
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "ssa_defines.svh"
module ssa_layout (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	// Save/restore unit requests
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire ssa_pkg::ssa_off_t req_offset_i,
	input wire logic [7:0] req_wdata_i,
	input wire logic mode64_i,
	output logic req_refused_o,
	output ssa_pkg::ssa_field_t req_field_o,
	output logic [7:0] restore_data_o,
	output logic restore_valid_o,
	output logic gp_fault_o,
	output logic fmt_compacted_o,
	output logic restore_compacted_o,
	// Memory side
	output ssa_pkg::ssa_word_t mem_addr_o,
	output logic mem_we_o,
	output logic mem_re_o,
	output logic [7:0] mem_be_o,
	output ssa_pkg::ssa_word_t mem_wdata_o,
	input wire ssa_pkg::ssa_word_t mem_rdata_i
);
	import ssa_pkg::*;

	// ==========================================================
	// Layout map and address generator
	ssa_map_if req_if ();
	ssa_map_if lk_if ();
	ssa_word_t base_reg, base_next;
	ssa_off_t lookup_off_reg, lookup_off_next;

	assign req_if.off = req_offset_i;
	assign req_if.base = base_reg;
	assign lk_if.off = lookup_off_reg;
	assign lk_if.base = base_reg;

	ssa_field_map u_req_map (
		.m(req_if.mapper)
	);
	ssa_field_map u_lookup_map (
		.m(lk_if.mapper)
	);
	ssa_addr_gen u_agen (
		.a(req_if.agen)
	);

	// ==========================================================
	// State
	logic [31:0] vmask_reg, vmask_next;
	ssa_word_t pres_reg, pres_next;
	ssa_word_t comp_reg, comp_next;
	logic gp_st_reg, gp_st_next;
	logic ref_st_reg, ref_st_next;
	logic form_reg, form_next;
	logic [31:0] vcs_acc_reg, vcs_acc_next;
	ssa_word_t mem_addr_reg, mem_addr_next;
	logic mem_we_reg, mem_we_next;
	logic mem_re_reg, mem_re_next;
	logic [7:0] mem_be_reg, mem_be_next;
	ssa_word_t mem_wdata_reg, mem_wdata_next;
	logic rd_pend_reg, rd_pend_next;
	ssa_field_t rd_fld_reg, rd_fld_next;
	logic [3:0] rd_fbyte_reg, rd_fbyte_next;
	logic [2:0] rd_lane_reg, rd_lane_next;
	logic [7:0] rst_data_reg, rst_data_next;
	logic rst_valid_reg, rst_valid_next;
	logic gp_reg, gp_next;
	logic refused_reg, refused_next;
	ssa_field_t req_fld_reg, req_fld_next;
	logic [31:0] rdata_reg, rdata_next;

	// ==========================================================
	// Request acceptance
	logic vec_hi;
	logic refuse;
	logic accept;
	logic [7:0] rd_byte;
	logic [31:0] vcs_full;
	logic [31:0] status_word;
	logic [31:0] lookup_word;

	// Upper vector slots exist only in 64-bit mode; elsewhere they are refused
	// so memory is neither written nor read for them.
	assign vec_hi = (req_if.fld == SSA_FLD_VEC) && req_if.reg_idx[3];
	assign refuse = req_valid_i && (req_if.rsvd || (vec_hi && !mode64_i));
	assign accept = req_valid_i && !refuse;
	assign rd_byte = mem_rdata_i[{rd_lane_reg, 3'h0} +: 8];
	assign vcs_full = {rd_byte, vcs_acc_reg[23:0]};
	assign status_word = {28'h0, form_reg, ref_st_reg, gp_st_reg, comp_reg[`SSA_FMT_BIT]};
	assign lookup_word = {17'h0, lk_if.rsvd, lk_if.comp_vec, lk_if.comp_fpu,
		lk_if.reg_idx, lk_if.fbyte, lk_if.fld};

	// ==========================================================
	// Memory access path
	always_comb begin
		mem_addr_next = mem_addr_reg;
		mem_we_next = 1'b0;
		mem_re_next = 1'b0;
		mem_be_next = 8'h00;
		mem_wdata_next = mem_wdata_reg;
		req_fld_next = req_fld_reg;
		refused_next = refuse;
		rd_fld_next = rd_fld_reg;
		rd_fbyte_next = rd_fbyte_reg;
		rd_lane_next = rd_lane_reg;
		if (req_valid_i) begin
			req_fld_next = req_if.fld;
		end
		if (accept) begin
			mem_addr_next = req_if.addr;
			mem_be_next = req_if.be;
			mem_we_next = req_write_i;
			mem_re_next = !req_write_i;
			mem_wdata_next = {8{req_wdata_i}};
		end
		// The read answer lands two cycles after the request, so its field and byte are
		// taken from the issued access; back-to-back requests would otherwise overwrite them.
		// The 64-byte aligned base keeps address bits 2:0 equal to offset bits 2:0.
		if (mem_re_reg) begin
			rd_fld_next = req_fld_reg;
			rd_fbyte_next = {1'b0, mem_addr_reg[2:0]};
			rd_lane_next = mem_addr_reg[2:0];
		end
		rd_pend_next = mem_re_reg;
	end

	// ==========================================================
	// Restore data, header shadows and vector control check
	always_comb begin
		pres_next = pres_reg;
		comp_next = comp_reg;
		form_next = form_reg;
		vcs_acc_next = vcs_acc_reg;
		rst_data_next = rst_data_reg;
		rst_valid_next = 1'b0;
		gp_next = 1'b0;
		// A save of a header byte updates the shadow at once.
		if (accept && req_write_i) begin
			if (req_if.fld == SSA_FLD_PRES) begin
				pres_next[{req_if.fbyte[2:0], 3'h0} +: 8] = req_wdata_i;
			end
			if (req_if.fld == SSA_FLD_COMP) begin
				comp_next[{req_if.fbyte[2:0], 3'h0} +: 8] = req_wdata_i;
			end
		end
		if (rd_pend_reg) begin
			rst_data_next = rd_byte;
			rst_valid_next = 1'b1;
			unique case (rd_fld_reg)
				SSA_FLD_PRES: begin
					pres_next[{rd_fbyte_reg[2:0], 3'h0} +: 8] = rd_byte;
				end
				SSA_FLD_COMP: begin
					comp_next[{rd_fbyte_reg[2:0], 3'h0} +: 8] = rd_byte;
					if (rd_fbyte_reg == `SSA_BM_LAST) begin
						form_next = rd_byte[7];
					end
				end
				SSA_FLD_VCS: begin
					vcs_acc_next[{rd_fbyte_reg[1:0], 3'h0} +: 8] = rd_byte;
					if (rd_fbyte_reg == `SSA_VCS_LAST) begin
						gp_next = |(vcs_full & ~vmask_reg);
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Register port
	always_comb begin
		base_next = base_reg;
		vmask_next = vmask_reg;
		lookup_off_next = lookup_off_reg;
		// Sticky flags: a new event in the clearing cycle keeps the flag set.
		gp_st_next = gp_st_reg | gp_next;
		ref_st_next = ref_st_reg | refuse;
		rdata_next = 32'h0;
		if (reg_we_i) begin
			unique case (reg_addr_i)
				`SSA_REG_BASE_LO: begin
					// The image base is 64-byte aligned; low bits read as zero.
					base_next[31:0] = {reg_wdata_i[31:`SSA_BASE_ALIGN], 6'h00};
				end
				`SSA_REG_BASE_HI: begin
					base_next[63:32] = reg_wdata_i;
				end
				`SSA_REG_VMASK: begin
					vmask_next = reg_wdata_i;
				end
				`SSA_REG_STATUS: begin
					gp_st_next = (gp_st_reg & ~reg_wdata_i[`SSA_ST_GP]) | gp_next;
					ref_st_next = (ref_st_reg & ~reg_wdata_i[`SSA_ST_REFUSE]) | refuse;
				end
				`SSA_REG_LOOKUP: begin
					lookup_off_next = reg_wdata_i[9:0];
				end
				default: begin
				end
			endcase
		end
		if (reg_re_i) begin
			unique case (reg_addr_i)
				`SSA_REG_BASE_LO: rdata_next = base_reg[31:0];
				`SSA_REG_BASE_HI: rdata_next = base_reg[63:32];
				`SSA_REG_VMASK: rdata_next = vmask_reg;
				`SSA_REG_STATUS: rdata_next = status_word;
				`SSA_REG_PRES_LO: rdata_next = pres_reg[31:0];
				`SSA_REG_PRES_HI: rdata_next = pres_reg[63:32];
				`SSA_REG_COMP_LO: rdata_next = comp_reg[31:0];
				`SSA_REG_COMP_HI: rdata_next = comp_reg[63:32];
				`SSA_REG_LOOKUP: rdata_next = lookup_word;
				default: rdata_next = 32'h0;
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			base_reg <= 64'h0;
			lookup_off_reg <= 10'h000;
			vmask_reg <= `SSA_VMASK_RST;
			pres_reg <= 64'h0;
			comp_reg <= 64'h0;
			gp_st_reg <= 1'b0;
			ref_st_reg <= 1'b0;
			form_reg <= 1'b0;
			vcs_acc_reg <= 32'h0;
			mem_addr_reg <= 64'h0;
			mem_we_reg <= 1'b0;
			mem_re_reg <= 1'b0;
			mem_be_reg <= 8'h00;
			mem_wdata_reg <= 64'h0;
			rd_pend_reg <= 1'b0;
			rd_fld_reg <= SSA_FLD_RSVD;
			rd_fbyte_reg <= 4'h0;
			rd_lane_reg <= 3'h0;
			rst_data_reg <= 8'h00;
			rst_valid_reg <= 1'b0;
			gp_reg <= 1'b0;
			refused_reg <= 1'b0;
			req_fld_reg <= SSA_FLD_RSVD;
			rdata_reg <= 32'h0;
		end else begin
			base_reg <= base_next;
			lookup_off_reg <= lookup_off_next;
			vmask_reg <= vmask_next;
			pres_reg <= pres_next;
			comp_reg <= comp_next;
			gp_st_reg <= gp_st_next;
			ref_st_reg <= ref_st_next;
			form_reg <= form_next;
			vcs_acc_reg <= vcs_acc_next;
			mem_addr_reg <= mem_addr_next;
			mem_we_reg <= mem_we_next;
			mem_re_reg <= mem_re_next;
			mem_be_reg <= mem_be_next;
			mem_wdata_reg <= mem_wdata_next;
			rd_pend_reg <= rd_pend_next;
			rd_fld_reg <= rd_fld_next;
			rd_fbyte_reg <= rd_fbyte_next;
			rd_lane_reg <= rd_lane_next;
			rst_data_reg <= rst_data_next;
			rst_valid_reg <= rst_valid_next;
			gp_reg <= gp_next;
			refused_reg <= refused_next;
			req_fld_reg <= req_fld_next;
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata_o = rdata_reg;
	assign req_refused_o = refused_reg;
	assign req_field_o = req_fld_reg;
	assign restore_data_o = rst_data_reg;
	assign restore_valid_o = rst_valid_reg;
	assign gp_fault_o = gp_reg;
	assign fmt_compacted_o = comp_reg[`SSA_FMT_BIT];
	assign restore_compacted_o = form_reg;
	assign mem_addr_o = mem_addr_reg;
	assign mem_we_o = mem_we_reg;
	assign mem_re_o = mem_re_reg;
	assign mem_be_o = mem_be_reg;
	assign mem_wdata_o = mem_wdata_reg;
endmodule : ssa_layout

// ---- core/ssa_map_if.sv ----
`timescale 1ns/1ps
interface ssa_map_if;
	import ssa_pkg::*;
	ssa_off_t off;
	ssa_word_t base;
	ssa_field_t fld;
	logic comp_fpu;
	logic comp_vec;
	logic [3:0] reg_idx;
	logic [3:0] fbyte;
	logic rsvd;
	ssa_word_t addr;
	logic [2:0] lane;
	logic [7:0] be;
	modport mapper (input off, output fld, comp_fpu, comp_vec, reg_idx, fbyte, rsvd);
	modport agen (input base, off, output addr, lane, be);
endinterface : ssa_map_if

// ---- core/ssa_pkg.sv ----
package ssa_pkg;
	typedef logic [9:0] ssa_off_t;
	typedef logic [63:0] ssa_word_t;
	typedef enum logic [3:0] {
		SSA_FLD_RSVD = 4'h0,
		SSA_FLD_FCW = 4'h1,
		SSA_FLD_FSW = 4'h2,
		SSA_FLD_TAG = 4'h3,
		SSA_FLD_FOP = 4'h4,
		SSA_FLD_FIP = 4'h5,
		SSA_FLD_FDP = 4'h6,
		SSA_FLD_VCS = 4'h7,
		SSA_FLD_VMASK = 4'h8,
		SSA_FLD_STK = 4'h9,
		SSA_FLD_VEC = 4'hA,
		SSA_FLD_PRES = 4'hB,
		SSA_FLD_COMP = 4'hC,
		SSA_FLD_EXT = 4'hD
	} ssa_field_t;
endpackage : ssa_pkg
